// *** core/cswc_clock_select.sv ***
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
module cswc_clock_select
  import cswc_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       nrst_in,
  input  wire cswc_bus_s  bus_in,
  output logic      [7:0] rdata_out,
  input  wire logic       pll_lock_in,
  input  wire logic       self_clock_in,
  input  wire logic       rti_event_in,
  input  wire logic       osc_type_in,
  input  wire logic       special_mode_in,
  input  wire cswc_mode_e mode_in,
  output logic            pll_clock_select_out,
  output logic            osc_enable_out,
  output logic            pll_power_out,
  output logic            rti_run_out,
  output logic            rti_reinit_out,
  output logic            wdog_run_out,
  output logic            wdog_reinit_out,
  output logic            wdog_service_out,
  output logic      [7:0] wdog_service_data_out,
  output logic      [7:0] pll_multiplier_out,
  output logic      [7:0] reference_divider_out,
  output logic      [4:0] post_divider_out,
  output logic      [7:0] pll_control_out,
  output logic      [7:0] periodic_rate_out,
  output logic      [7:0] watchdog_control_out,
  output logic            irq_out
);

  logic [7:0] mult_q, refdiv_q, irqen_q, pll_control_q, rate_q, wdog_q;
  logic [4:0] post_divider_q;
  logic       pll_sel_q, pstop_q, pll_wait_q, rti_wait_q, wdog_wait_q;
  logic       wdog_wait_locked_q;
  logic       lock_q, scm_q;
  logic [7:0] stat_q;
  cswc_mode_e mode_q;
  logic       wait_entry, stop_entry, scm_entry;
  logic       wr_en, rd_en;
  logic [7:0] rd_mux;
  logic [7:0] stat_set;

  assign wr_en = bus_in.wr;
  assign rd_en = bus_in.rd;
  assign wait_entry = (mode_in == CSWC_WAIT) && (mode_q != CSWC_WAIT);
  assign stop_entry = (mode_in == CSWC_STOP) && (mode_q != CSWC_STOP);
  assign scm_entry  = self_clock_in && !scm_q;

  // Mode entry is a change of the mode input against last cycle's copy
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      mode_q <= CSWC_RUN;
    end else begin
      mode_q <= mode_in;
    end
  end

  // Lock copy feeds both the change flag and the live status bit
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= pll_lock_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      scm_q <= 1'b0;
    end else begin
      scm_q <= self_clock_in;
    end
  end

  // Plain read-write configuration registers
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      mult_q <= CSWC_RST_MULT;
    end else if (wr_en && bus_in.addr == CSWC_OFS_PLL_MULTIPLIER) begin
      mult_q <= bus_in.wdata;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      refdiv_q <= CSWC_RST_REFDIV;
    end else if (wr_en && bus_in.addr == CSWC_OFS_REFERENCE_DIV) begin
      refdiv_q <= bus_in.wdata;
    end
  end

  // Upper three bits are unimplemented and never stored
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      post_divider_q <= CSWC_RST_POST_DIVIDER[4:0];
    end else if (wr_en && bus_in.addr == CSWC_OFS_POST_DIVIDER) begin
      post_divider_q <= bus_in.wdata[4:0] & CSWC_POST_DIVIDER_MASK;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      irqen_q <= CSWC_RST_IRQEN;
    end else if (wr_en && bus_in.addr == CSWC_OFS_IRQ_ENABLE) begin
      irqen_q <= bus_in.wdata & CSWC_IRQ_MASK;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      pll_control_q <= CSWC_RST_PLL_CONTROL;
    end else if (wr_en && bus_in.addr == CSWC_OFS_PLL_CONTROL) begin
      pll_control_q <= bus_in.wdata;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      rate_q <= CSWC_RST_RATE;
    end else if (wr_en && bus_in.addr == CSWC_OFS_PERIODIC_RATE) begin
      rate_q <= bus_in.wdata;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      wdog_q <= CSWC_RST_WDOG;
    end else if (wr_en && bus_in.addr == CSWC_OFS_WATCHDOG_CTRL) begin
      wdog_q <= bus_in.wdata;
    end
  end

  // Clock select register; hardware clears win over a same-cycle write
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      pll_sel_q  <= CSWC_RST_SELECT[CSWC_SEL_PLL];
      pstop_q    <= CSWC_RST_SELECT[CSWC_SEL_PSTOP];
      pll_wait_q <= CSWC_RST_SELECT[CSWC_SEL_PLL_WAIT];
      rti_wait_q <= CSWC_RST_SELECT[CSWC_SEL_RTI_WAIT];
    end else begin
      if (wr_en && bus_in.addr == CSWC_OFS_CLOCK_SELECT) begin
        pstop_q    <= bus_in.wdata[CSWC_SEL_PSTOP];
        pll_wait_q <= bus_in.wdata[CSWC_SEL_PLL_WAIT];
        rti_wait_q <= bus_in.wdata[CSWC_SEL_RTI_WAIT];
        if (!bus_in.wdata[CSWC_SEL_PLL]) begin
          pll_sel_q <= 1'b0;
        end else if (pll_lock_in) begin
          pll_sel_q <= 1'b1;
        end
      end
      if (scm_entry || stop_entry || (wait_entry && pll_wait_q)) begin
        pll_sel_q <= 1'b0;
      end
    end
  end

  // Watchdog stop-in-wait is write-once outside special modes
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      wdog_wait_q        <= CSWC_RST_SELECT[CSWC_SEL_WDOG_WAIT];
      wdog_wait_locked_q <= 1'b0;
    end else if (wr_en && bus_in.addr == CSWC_OFS_CLOCK_SELECT) begin
      if (special_mode_in || !wdog_wait_locked_q) begin
        wdog_wait_q <= bus_in.wdata[CSWC_SEL_WDOG_WAIT];
      end
      wdog_wait_locked_q <= 1'b1;
    end
  end

  // Sticky status: set beats clear
  always_comb begin
    stat_set = 8'h00;
    stat_set[CSWC_FLG_RTI]    = rti_event_in;
    stat_set[CSWC_FLG_LOCK_CHANGE_FLAG] = pll_lock_in ^ lock_q;
    stat_set[CSWC_FLG_SELF_CLOCK_CHANGE_FLAG]  = self_clock_in ^ scm_q;
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      stat_q <= 8'h00;
    end else if (wr_en && bus_in.addr == CSWC_OFS_IRQ_CLEAR) begin
      stat_q <= (stat_q & ~bus_in.wdata) | stat_set;
    end else begin
      stat_q <= stat_q | stat_set;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |((stat_q | stat_set) & irqen_q & CSWC_IRQ_MASK);
    end
  end

  // Read mux; factory test and write-only registers read zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (bus_in.addr)
      CSWC_OFS_PLL_MULTIPLIER: rd_mux = mult_q;
      CSWC_OFS_REFERENCE_DIV:  rd_mux = refdiv_q;
      CSWC_OFS_POST_DIVIDER:   rd_mux = {3'b000, post_divider_q};
      CSWC_OFS_CLOCK_FLAGS: begin
        rd_mux = stat_q & CSWC_IRQ_MASK;
        rd_mux[CSWC_FLG_LOCK] = lock_q;
        rd_mux[CSWC_FLG_SCM]  = scm_q;
      end
      CSWC_OFS_IRQ_ENABLE:     rd_mux = irqen_q;
      CSWC_OFS_CLOCK_SELECT: begin
        rd_mux[CSWC_SEL_PLL]       = pll_sel_q;
        rd_mux[CSWC_SEL_PSTOP]     = pstop_q;
        rd_mux[CSWC_SEL_OSC_TYPE]  = osc_type_in;
        rd_mux[CSWC_SEL_PLL_WAIT]  = pll_wait_q;
        rd_mux[CSWC_SEL_RTI_WAIT]  = rti_wait_q;
        rd_mux[CSWC_SEL_WDOG_WAIT] = wdog_wait_q;
      end
      CSWC_OFS_PLL_CONTROL:    rd_mux = pll_control_q;
      CSWC_OFS_PERIODIC_RATE:  rd_mux = rate_q;
      CSWC_OFS_WATCHDOG_CTRL:  rd_mux = wdog_q;
      CSWC_OFS_IRQ_STATUS:     rd_mux = stat_q & CSWC_IRQ_MASK;
      CSWC_OFS_FACTORY_TEST, CSWC_OFS_FACTORY_BYPASS: rd_mux = 8'h00;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= rd_en ? rd_mux : 8'h00;
    end
  end

  // Power and wait-mode control outputs, one register each
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      pll_clock_select_out <= 1'b0;
    end else begin
      pll_clock_select_out <= pll_sel_q;
    end
  end

  // Oscillator stays on in stop only when pseudo stop is chosen
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      osc_enable_out <= 1'b1;
    end else begin
      osc_enable_out <= (mode_in != CSWC_STOP) || pstop_q;
    end
  end

  // Power-on bit is left alone; only the power request drops, in stop and in wait with PLL wait set
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      pll_power_out <= 1'b0;
    end else begin
      pll_power_out <= pll_control_q[CSWC_PLL_ON] && (mode_in != CSWC_STOP)
                       && !((mode_in == CSWC_WAIT) && pll_wait_q);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      rti_run_out <= 1'b1;
    end else begin
      rti_run_out <= !((mode_in == CSWC_WAIT) && rti_wait_q);
    end
  end

  // A rate write restarts the timer too, so its dividers start clean
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      rti_reinit_out <= 1'b0;
    end else begin
      rti_reinit_out <= (wait_entry && rti_wait_q)
                        || (wr_en && bus_in.addr == CSWC_OFS_PERIODIC_RATE);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      wdog_run_out <= 1'b1;
    end else begin
      wdog_run_out <= !((mode_in == CSWC_WAIT) && wdog_wait_q);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      wdog_reinit_out <= 1'b0;
    end else begin
      wdog_reinit_out <= wait_entry && wdog_wait_q;
    end
  end

  // Service register is write-only; the watchdog sees a one-cycle pulse
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      wdog_service_out <= 1'b0;
    end else begin
      wdog_service_out <= wr_en && (bus_in.addr == CSWC_OFS_WATCHDOG_SVC);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      wdog_service_data_out <= 8'h00;
    end else begin
      wdog_service_data_out <= bus_in.wdata;
    end
  end

  // Registered copies cost a cycle of lag but keep the outputs glitch free
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      pll_multiplier_out <= CSWC_RST_MULT;
    end else begin
      pll_multiplier_out <= mult_q;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      reference_divider_out <= CSWC_RST_REFDIV;
    end else begin
      reference_divider_out <= refdiv_q;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      post_divider_out <= CSWC_RST_POST_DIVIDER[4:0];
    end else begin
      post_divider_out <= post_divider_q;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      pll_control_out <= CSWC_RST_PLL_CONTROL;
    end else begin
      pll_control_out <= pll_control_q;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      periodic_rate_out <= CSWC_RST_RATE;
    end else begin
      periodic_rate_out <= rate_q;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      watchdog_control_out <= CSWC_RST_WDOG;
    end else begin
      watchdog_control_out <= wdog_q;
    end
  end

endmodule // cswc_clock_select

// *** core/cswc_pkg.sv ***
package cswc_pkg;

  localparam logic [3:0] CSWC_OFS_PLL_MULTIPLIER  = 4'h0;
  localparam logic [3:0] CSWC_OFS_REFERENCE_DIV   = 4'h1;
  localparam logic [3:0] CSWC_OFS_POST_DIVIDER    = 4'h2;
  localparam logic [3:0] CSWC_OFS_CLOCK_FLAGS     = 4'h3;
  localparam logic [3:0] CSWC_OFS_IRQ_ENABLE      = 4'h4;
  localparam logic [3:0] CSWC_OFS_CLOCK_SELECT    = 4'h5;
  localparam logic [3:0] CSWC_OFS_PLL_CONTROL     = 4'h6;
  localparam logic [3:0] CSWC_OFS_PERIODIC_RATE   = 4'h7;
  localparam logic [3:0] CSWC_OFS_WATCHDOG_CTRL   = 4'h8;
  localparam logic [3:0] CSWC_OFS_FACTORY_BYPASS  = 4'h9;
  localparam logic [3:0] CSWC_OFS_FACTORY_TEST    = 4'hA;
  localparam logic [3:0] CSWC_OFS_WATCHDOG_SVC    = 4'hB;
  localparam logic [3:0] CSWC_OFS_IRQ_STATUS      = 4'hC;
  localparam logic [3:0] CSWC_OFS_IRQ_CLEAR       = 4'hD;

  // Bit positions in clock_select
  localparam int CSWC_SEL_PLL       = 7;
  localparam int CSWC_SEL_PSTOP     = 6;
  localparam int CSWC_SEL_OSC_TYPE  = 5;
  localparam int CSWC_SEL_PLL_WAIT  = 3;
  localparam int CSWC_SEL_RTI_WAIT  = 1;
  localparam int CSWC_SEL_WDOG_WAIT = 0;
  localparam logic [7:0] CSWC_SEL_WMASK = 8'hCB;

  // Bit positions in flags; RTI and the two change flags also in irq enable
  localparam int CSWC_FLG_RTI    = 7;
  localparam int CSWC_FLG_LOCK_CHANGE_FLAG = 4;
  localparam int CSWC_FLG_LOCK   = 3;
  localparam int CSWC_FLG_SELF_CLOCK_CHANGE_FLAG  = 1;
  localparam int CSWC_FLG_SCM    = 0;
  localparam logic [7:0] CSWC_IRQ_MASK = 8'h92;

  // Bit positions in pll_control
  localparam int CSWC_PLL_ON = 6;

  localparam logic [7:0] CSWC_RST_MULT     = 8'h00;
  localparam logic [7:0] CSWC_RST_REFDIV   = 8'h00;
  localparam logic [7:0] CSWC_RST_POST_DIVIDER  = 8'h00;
  localparam logic [7:0] CSWC_RST_IRQEN    = 8'h00;
  localparam logic [7:0] CSWC_RST_SELECT   = 8'h00;
  localparam logic [7:0] CSWC_RST_PLL_CONTROL   = 8'hC1;
  localparam logic [7:0] CSWC_RST_RATE     = 8'h00;
  localparam logic [7:0] CSWC_RST_WDOG     = 8'h00;
  localparam logic [4:0] CSWC_POST_DIVIDER_MASK = 5'h1F;

  // Bus clock is source divided by this
  localparam int CSWC_BUS_DIV = 2;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cswc_bus_s;

  typedef enum logic [1:0] {
    CSWC_RUN  = 2'b00,
    CSWC_WAIT = 2'b01,
    CSWC_STOP = 2'b10
  } cswc_mode_e;

endpackage

// *** tb/cswc_clock_select_checker.sv ***
`timescale 1ns/100ps
module cswc_clock_select_checker
  import cswc_pkg::*;
(
  input wire logic       clock_in,
  input wire logic       nrst_in,
  input wire cswc_bus_s  bus_in,
  input wire logic [7:0] rdata_out,
  input wire logic       pll_lock_in,
  input wire logic       osc_type_in,
  input wire cswc_mode_e mode_in,
  input wire logic       pll_clock_select_out,
  input wire logic       osc_enable_out,
  input wire logic       pll_power_out,
  input wire logic       wdog_reinit_out,
  input wire logic       wdog_service_out,
  input wire logic [7:0] wdog_service_data_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // Output lags the register by one, so the cause sits two edges back
  a_sel_needs_lock: assert property ($rose(pll_clock_select_out) |->
    $past(pll_lock_in, 2) && $past(bus_in.wdata[7], 2)) else $error("select set unlocked");
  a_stop_clears: assert property ($changed(mode_in) && mode_in == CSWC_STOP
    |-> ##[1:3] !pll_clock_select_out) else $error("select kept in stop");
  a_osc_off_stop: assert property (!osc_enable_out |->
    $past(mode_in) == CSWC_STOP) else $error("oscillator off outside stop");
  a_pll_off_stop: assert property (mode_in == CSWC_STOP |=>
    !pll_power_out) else $error("pll powered in stop");
  a_wdog_reinit: assert property (wdog_reinit_out |->
    $past(mode_in) == CSWC_WAIT) else $error("watchdog reinit outside wait");
  a_rdata_idle: assert property (!$past(bus_in.rd) |->
    rdata_out == 8'h00) else $error("read data without read");
  a_rsvd_zero: assert property (bus_in.rd && (bus_in.addr == CSWC_OFS_FACTORY_BYPASS ||
    bus_in.addr == CSWC_OFS_FACTORY_TEST) |=> rdata_out == 8'h00) else $error("test reg nonzero");
  a_osc_type_ro: assert property (bus_in.rd && bus_in.addr == CSWC_OFS_CLOCK_SELECT |=>
    rdata_out[CSWC_SEL_OSC_TYPE] == $past(osc_type_in)) else $error("osc type wrong");
  a_svc_pulse: assert property (bus_in.wr && bus_in.addr == CSWC_OFS_WATCHDOG_SVC |=>
    wdog_service_out && wdog_service_data_out == $past(bus_in.wdata)) else $error("no service");
endmodule // cswc_clock_select_checker

// *** tb/test_clock_select_wait_control.sv ***
`timescale 1ns/100ps
module test_clock_select_wait_control;
  import cswc_pkg::*;
  logic        clock_in = 1'b0;
  logic        nrst_in = 1'b0;
  cswc_bus_s   bus = '0;
  logic [7:0]  rdata_out;
  logic        lock = 1'b0, selfc = 1'b0, rti_ev = 1'b0, osc_t = 1'b1, spec = 1'b0;
  cswc_mode_e  mode = CSWC_RUN;
  logic        sel, osc_en, pll_pw, rti_run, wdog_run, irq, rd_pend = 1'b0;
  logic [31:0] lfsr = 32'hAF50;
  logic [7:0]  mult_o;
  logic [7:0]  exp_q[$];
  int          miscompares = 0, compares = 0, cycles = 0;

  cswc_clock_select dut (.clock_in(clock_in), .nrst_in(nrst_in), .bus_in(bus),
    .rdata_out(rdata_out), .pll_lock_in(lock), .self_clock_in(selfc), .rti_event_in(rti_ev),
    .osc_type_in(osc_t), .special_mode_in(spec), .mode_in(mode), .pll_clock_select_out(sel),
    .osc_enable_out(osc_en), .pll_power_out(pll_pw), .rti_run_out(rti_run),
    .rti_reinit_out(), .wdog_run_out(wdog_run), .wdog_reinit_out(), .wdog_service_out(),
    .wdog_service_data_out(), .pll_multiplier_out(mult_o), .reference_divider_out(),
    .post_divider_out(), .pll_control_out(), .periodic_rate_out(),
    .watchdog_control_out(), .irq_out(irq));

  always #50 clock_in = ~clock_in;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: level %b expected %b", $time, g, e);
    end
  endtask

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: read %h expected %h", $time, g, e);
    end
  endtask

  task automatic op(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge clock_in);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
  endtask

  // Expectation is queued before the strobe so the watcher never pops early
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    op(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 4'h0, 8'h00);
    @(negedge clock_in);
  endtask

  always @(posedge clock_in) begin
    if (rd_pend) begin
      chk_byte(rdata_out, exp_q.pop_front());
    end
    rd_pend <= bus.rd;
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge clock_in);
    nrst_in <= 1'b1;
    @(posedge clock_in);
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], a == 5 ? 8'h20 : a == 6 ? 8'hC1 : 8'h00);
    end
    wr(4'h5, 8'h01);
    wr(4'h5, 8'h00);
    rd(4'h5, 8'h21);
    spec <= 1'b1;
    wr(4'h5, 8'h00);
    rd(4'h5, 8'h20);
    repeat (3) begin
      lfsr = lfsr_next(lfsr);
      foreach (lfsr[i]) if (i < 4) wr({2'b00, i[1:0]} ^ 4'h0, 8'h00);
      wr(4'h0, lfsr[7:0]);
      wr(4'h1, lfsr[15:8]);
      wr(4'h2, lfsr[23:16]);
      wr(4'h7, lfsr[31:24]);
      wr(4'h9, lfsr[7:0]);
      wr(4'hA, lfsr[15:8]);
      wr(4'hB, lfsr[23:16]);
      rd(4'h0, lfsr[7:0]);
      rd(4'h1, lfsr[15:8]);
      rd(4'h2, {3'b000, lfsr[20:16]});
      rd(4'h7, lfsr[31:24]);
      rd(4'h9, 8'h00);
      rd(4'hA, 8'h00);
    end
    chk_byte(mult_o, lfsr[7:0]);
    wr(4'h5, 8'h80);
    rd(4'h5, 8'h20);
    idle(2);
    chk_bit(sel, 1'b0);
    @(posedge clock_in);
    lock <= 1'b1;
    wr(4'h5, 8'h80);
    rd(4'h5, 8'hA0);
    idle(1);
    chk_bit(sel, 1'b1);
    @(posedge clock_in);
    mode <= CSWC_STOP;
    idle(3);
    chk_bit(sel, 1'b0);
    chk_bit(osc_en, 1'b0);
    @(posedge clock_in);
    mode <= CSWC_RUN;
    wr(4'h5, 8'hC0);
    idle(2);
    @(posedge clock_in);
    mode <= CSWC_STOP;
    idle(3);
    chk_bit(osc_en, 1'b1);
    chk_bit(sel, 1'b0);
    @(posedge clock_in);
    mode <= CSWC_RUN;
    wr(4'h5, 8'h80);
    idle(2);
    @(posedge clock_in);
    selfc <= 1'b1;
    idle(3);
    chk_bit(sel, 1'b0);
    @(posedge clock_in);
    selfc <= 1'b0;
    wr(4'h5, 8'h8B);
    idle(2);
    @(posedge clock_in);
    mode <= CSWC_WAIT;
    idle(3);
    chk_bit(sel, 1'b0);
    chk_bit(pll_pw, 1'b0);
    chk_bit(rti_run, 1'b0);
    chk_bit(wdog_run, 1'b0);
    @(posedge clock_in);
    rd(4'h6, 8'hC1);
    mode <= CSWC_RUN;
    rd(4'h5, 8'h2B);
    wr(4'h5, 8'h80);
    idle(2);
    @(posedge clock_in);
    mode <= CSWC_WAIT;
    idle(3);
    chk_bit(sel, 1'b1);
    chk_bit(pll_pw, 1'b1);
    chk_bit(rti_run, 1'b1);
    chk_bit(wdog_run, 1'b1);
    @(posedge clock_in);
    mode <= CSWC_RUN;
    wr(4'hD, 8'hFF);
    wr(4'h4, 8'h00);
    rti_ev <= 1'b1;
    op(1'b0, 1'b0, 4'h0, 8'h00);
    rti_ev <= 1'b0;
    idle(2);
    chk_bit(irq, 1'b0);
    @(posedge clock_in);
    rd(4'hC, 8'h80);
    wr(4'h4, 8'h80);
    idle(2);
    chk_bit(irq, 1'b1);
    @(posedge clock_in);
    wr(4'hD, 8'h80);
    rd(4'hC, 8'h00);
    idle(2);
    chk_bit(irq, 1'b0);
    @(posedge clock_in);
    wr(4'h4, 8'h10);
    lock <= 1'b0;
    idle(3);
    chk_bit(irq, 1'b1);
    @(posedge clock_in);
    idle(3);
    give_verdict();
  end
endmodule // test_clock_select_wait_control

bind cswc_clock_select cswc_clock_select_checker chk (.clock_in(clock_in), .nrst_in(nrst_in),
  .bus_in(bus_in), .rdata_out(rdata_out), .pll_lock_in(pll_lock_in), .osc_type_in(osc_type_in),
  .mode_in(mode_in), .pll_clock_select_out(pll_clock_select_out),
  .osc_enable_out(osc_enable_out), .pll_power_out(pll_power_out),
  .wdog_reinit_out(wdog_reinit_out), .wdog_service_out(wdog_service_out),
  .wdog_service_data_out(wdog_service_data_out));
